// [rtl/acs_sequencer_top.sv]
// conversion mode sequencer: wishbone registers, result store, flags
// assumes the analog side answers each conv_start with one conv_done
// pulse carrying conv_result, and drops a conversion on conv_abort
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_top (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    output logic conv_start,
    output logic [3:0] conv_channel,
    output logic conv_abort,
    output logic [7:0] timing_control,
    input wire logic conv_done,
    input wire logic [9:0] conv_result
);
    acs_bus_if bus ();

    acs_wb_slave u_slave (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .bus(bus)
    );

    acs_pkg::acs_state_type state;
    acs_pkg::acs_state_type next_state;
    logic [2:0] idx;
    logic [2:0] next_idx;
    logic [7:0] ccf;
    logic [7:0] next_ccf;
    logic sequence_complete_flag;
    logic next_scf;
    logic [acs_pkg::SEQ_W-1:0] seq_ctl;
    logic [acs_pkg::SEQ_W-1:0] next_seq_ctl;
    logic [7:0] next_timing;
    logic [acs_pkg::IRQ_W-1:0] irq_status;
    logic [acs_pkg::IRQ_W-1:0] next_irq_status;
    logic [acs_pkg::IRQ_W-1:0] irq_mask;
    logic [acs_pkg::IRQ_W-1:0] next_irq_mask;
    logic [9:0] result [0:7];
    logic [9:0] next_result [0:7];
    logic [3:0] next_channel;
    logic next_abort;
    logic wr_timing;
    logic wr_seq;
    logic done_take;
    logic at_last;
    logic [2:0] mode;
    logic [acs_pkg::IRQ_W-1:0] irq_event;
    logic [acs_pkg::IRQ_W-1:0] irq_clear;
    logic [31:0] read_value;

    assign wr_timing = bus.wr && (bus.adr == acs_pkg::OFS_TIMING);
    assign wr_seq = bus.wr && (bus.adr == acs_pkg::OFS_SEQ);
    assign mode = acs_pkg::mode_number(seq_ctl[acs_pkg::SEQ_SCAN_BIT],
        seq_ctl[acs_pkg::SEQ_MULTI_BIT],
        seq_ctl[acs_pkg::SEQ_LEN_BIT]);
    assign at_last = (idx == acs_pkg::last_index(mode[0]));
    // a timing or sequence write in the same cycle discards the finishing conversion
    assign done_take = (state == acs_pkg::ST_WAIT) && conv_done
        && !wr_timing && !wr_seq;

    // sequence control and result store
    always_comb begin
        next_state = state;
        next_idx = idx;
        next_ccf = ccf;
        next_scf = sequence_complete_flag;
        next_seq_ctl = seq_ctl;
        next_timing = timing_control;
        next_abort = 1'b0;
        for (int i = 0; i < acs_pkg::NUM_RESULTS; i++) begin
            next_result[i] = result[i];
        end
        if (wr_timing) begin
            next_timing = bus.wdata[7:0];
            next_state = acs_pkg::ST_IDLE;
            next_idx = 3'h0;
            next_ccf = 8'h00;
            next_scf = 1'b0;
            next_abort = (state != acs_pkg::ST_IDLE);
        end else if (wr_seq) begin
            next_seq_ctl = bus.wdata[acs_pkg::SEQ_W-1:0];
            next_state = acs_pkg::ST_START;
            next_idx = 3'h0;
            next_ccf = 8'h00;
            next_scf = 1'b0;
            next_abort = (state != acs_pkg::ST_IDLE);
        end else begin
            case (state)
                acs_pkg::ST_IDLE: begin
                    next_state = acs_pkg::ST_IDLE;
                end
                acs_pkg::ST_START: begin
                    next_state = acs_pkg::ST_WAIT;
                end
                acs_pkg::ST_WAIT: begin
                    if (done_take) begin
                        next_result[idx] = conv_result;
                        next_ccf[idx] = 1'b1;
                        if (at_last) begin
                            next_scf = 1'b1;
                            next_idx = 3'h0;
                            if (mode[2]) begin
                                next_state = acs_pkg::ST_START;
                            end else begin
                                next_state = acs_pkg::ST_IDLE;
                            end
                        end else begin
                            next_idx = idx + 3'h1;
                            next_state = acs_pkg::ST_START;
                        end
                    end
                end
                default: begin
                    next_state = acs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    acs_channel_map u_map (
        .multi(next_seq_ctl[acs_pkg::SEQ_MULTI_BIT]),
        .len8(next_seq_ctl[acs_pkg::SEQ_LEN_BIT]),
        .sel(next_seq_ctl[acs_pkg::SEQ_SEL_LSB +: acs_pkg::CH_W]),
        .idx(next_idx),
        .channel(next_channel)
    );

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state <= acs_pkg::ST_IDLE;
            idx <= 3'h0;
            ccf <= 8'h00;
            sequence_complete_flag <= 1'b0;
            seq_ctl <= acs_pkg::SEQ_RESET;
            timing_control <= acs_pkg::TIMING_RESET;
            conv_channel <= 4'h0;
            conv_abort <= 1'b0;
            for (int i = 0; i < acs_pkg::NUM_RESULTS; i++) begin
                result[i] <= 10'h000;
            end
        end else begin
            state <= next_state;
            idx <= next_idx;
            ccf <= next_ccf;
            sequence_complete_flag <= next_scf;
            seq_ctl <= next_seq_ctl;
            timing_control <= next_timing;
            conv_channel <= next_channel;
            conv_abort <= next_abort;
            for (int i = 0; i < acs_pkg::NUM_RESULTS; i++) begin
                result[i] <= next_result[i];
            end
        end
    end

    assign conv_start = (state == acs_pkg::ST_START);

    // interrupt status, write one to clear, a new event wins
    always_comb begin
        irq_event = '0;
        irq_event[acs_pkg::IRQ_SEQ_BIT] = next_scf & ~sequence_complete_flag;
        irq_event[acs_pkg::IRQ_CONV_BIT] = done_take;
        irq_clear = '0;
        if (bus.wr && (bus.adr == acs_pkg::OFS_IRQ_STATUS)) begin
            irq_clear = bus.wdata[acs_pkg::IRQ_W-1:0];
        end
        next_irq_status = (irq_status & ~irq_clear) | irq_event;
        next_irq_mask = irq_mask;
        if (bus.wr && (bus.adr == acs_pkg::OFS_IRQ_MASK)) begin
            next_irq_mask = bus.wdata[acs_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            irq_status <= acs_pkg::IRQ_RESET;
            irq_mask <= acs_pkg::IRQ_RESET;
        end else begin
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // read decode; unmapped offsets read zero
    always_comb begin
        read_value = 32'h0000_0000;
        case (bus.adr)
            acs_pkg::OFS_TIMING: begin
                read_value[7:0] = timing_control;
            end
            acs_pkg::OFS_SEQ: begin
                read_value[acs_pkg::SEQ_W-1:0] = seq_ctl;
            end
            acs_pkg::OFS_STATUS: begin
                read_value[7:0] = ccf;
                read_value[acs_pkg::STAT_SCF_BIT] = sequence_complete_flag;
                read_value[acs_pkg::STAT_BUSY_BIT] =
                    (state != acs_pkg::ST_IDLE);
                read_value[acs_pkg::STAT_MODE_LSB +: 3] = mode;
            end
            acs_pkg::OFS_IRQ_STATUS: begin
                read_value[acs_pkg::IRQ_W-1:0] = irq_status;
            end
            acs_pkg::OFS_IRQ_MASK: begin
                read_value[acs_pkg::IRQ_W-1:0] = irq_mask;
            end
            default: begin
                if ((bus.adr[7:5] == acs_pkg::OFS_RESULT_PAGE)
                    && (bus.adr[1:0] == 2'h0)) begin
                    read_value[9:0] = result[bus.adr[4:2]];
                end
            end
        endcase
    end

    assign bus.rdata = read_value;

    // checks
    sequence s_take_last;
        done_take && at_last;
    endsequence

    sequence s_take_mid;
        done_take && !at_last;
    endsequence

    property p_seq_restart;
        @(posedge sys_clk) disable iff (!reset_n)
        wr_seq |=> conv_start && (idx == 3'h0) && (ccf == 8'h00) && !sequence_complete_flag;
    endproperty
    a_seq_restart: assert property (p_seq_restart)
        else $error("sequence write did not restart cleanly");

    property p_timing_halt;
        @(posedge sys_clk) disable iff (!reset_n)
        wr_timing |=> (state == acs_pkg::ST_IDLE) && (ccf == 8'h00)
            && !sequence_complete_flag ##1 !conv_start;
    endproperty
    a_timing_halt: assert property (p_timing_halt)
        else $error("timing write did not halt");

    property p_flag_on_store;
        @(posedge sys_clk) disable iff (!reset_n)
        done_take |=> ccf[$past(idx)]
            && (result[$past(idx)] == $past(conv_result));
    endproperty
    a_flag_on_store: assert property (p_flag_on_store)
        else $error("result or completion flag not stored");

    property p_single_stop;
        @(posedge sys_clk) disable iff (!reset_n)
        s_take_last ##0 !mode[2] |=> sequence_complete_flag && (state == acs_pkg::ST_IDLE)
            ##1 !conv_start;
    endproperty
    a_single_stop: assert property (p_single_stop)
        else $error("single sequence did not stop with flag");

    property p_scan_continue;
        @(posedge sys_clk) disable iff (!reset_n)
        s_take_last ##0 mode[2] |=> sequence_complete_flag && conv_start && (idx == 3'h0);
    endproperty
    a_scan_continue: assert property (p_scan_continue)
        else $error("continuous mode did not wrap and continue");

    property p_advance;
        @(posedge sys_clk) disable iff (!reset_n)
        s_take_mid |=> conv_start && (idx == $past(idx) + 3'h1)
            && ($stable(sequence_complete_flag));
    endproperty
    a_advance: assert property (p_advance)
        else $error("result index did not advance");

    property p_single_channel;
        @(posedge sys_clk) disable iff (!reset_n)
        conv_start && !mode[1] |-> conv_channel == seq_ctl[3:0];
    endproperty
    a_single_channel: assert property (p_single_channel)
        else $error("single channel select mismatch");

    property p_block_four;
        @(posedge sys_clk) disable iff (!reset_n)
        conv_start && mode[1] && !mode[0]
            |-> conv_channel == {seq_ctl[3:2], idx[1:0]};
    endproperty
    a_block_four: assert property (p_block_four)
        else $error("four channel block mismatch");

    property p_block_eight;
        @(posedge sys_clk) disable iff (!reset_n)
        conv_start && mode[1] && mode[0]
            |-> conv_channel == {seq_ctl[3], idx};
    endproperty
    a_block_eight: assert property (p_block_eight)
        else $error("eight channel block mismatch");

    property p_four_bound;
        @(posedge sys_clk) disable iff (!reset_n)
        !mode[0] && (state != acs_pkg::ST_IDLE) |-> idx <= 3'h3;
    endproperty
    a_four_bound: assert property (p_four_bound)
        else $error("four conversion sequence overran");
endmodule : acs_sequencer_top
`default_nettype wire

// [rtl/acs_pkg.sv]
// constants, types and helpers for the conversion sequencer
// assumes a 100 MHz sys_clk and a classic wishbone register port
package acs_pkg;
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int RES_W = 10;
    localparam int CH_W = 4;
    localparam int NUM_RESULTS = 8;

    // byte offsets
    localparam logic [7:0] OFS_TIMING = 8'h00;
    localparam logic [7:0] OFS_SEQ = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [2:0] OFS_RESULT_PAGE = 3'h1;

    // sequence control fields
    localparam int SEQ_SEL_LSB = 0;
    localparam int SEQ_LEN_BIT = 4;
    localparam int SEQ_MULTI_BIT = 5;
    localparam int SEQ_SCAN_BIT = 6;
    localparam int SEQ_W = 7;

    // status fields
    localparam int STAT_SCF_BIT = 8;
    localparam int STAT_BUSY_BIT = 9;
    localparam int STAT_MODE_LSB = 10;

    // interrupt bits
    localparam int IRQ_SEQ_BIT = 0;
    localparam int IRQ_CONV_BIT = 1;
    localparam int IRQ_W = 2;

    // reset values
    localparam logic [7:0] TIMING_RESET = 8'h00;
    localparam logic [SEQ_W-1:0] SEQ_RESET = 7'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

    // last result index for four and eight conversion sequences
    localparam logic [2:0] LAST_IDX_FOUR = 3'h3;
    localparam logic [2:0] LAST_IDX_EIGHT = 3'h7;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_WAIT = 2'b10
    } acs_state_type;

    function automatic logic [2:0] last_index(input logic len8);
        last_index = len8 ? LAST_IDX_EIGHT : LAST_IDX_FOUR;
    endfunction : last_index

    function automatic logic [2:0] mode_number(input logic scan,
                                               input logic multi,
                                               input logic len8);
        mode_number = {scan, multi, len8};
    endfunction : mode_number
endpackage : acs_pkg

// [rtl/acs_bus_if.sv]
// register access carrier between the wishbone slave and the core
// assumes one clock domain, sys_clk
`timescale 1ns/1ps
`default_nettype none
interface acs_bus_if;
    logic wr;
    logic [7:0] adr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport slave (output wr, output adr, output wdata, input rdata);
    modport core (input wr, input adr, input wdata, output rdata);
endinterface : acs_bus_if
`default_nettype wire

// [rtl/acs_wb_slave.sv]
// classic wishbone slave, one wait state, registered read data
// assumes the master holds its request until it sees ack
`timescale 1ns/1ps
`default_nettype none
module acs_wb_slave (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    acs_bus_if.slave bus
);
    logic next_ack;
    logic [31:0] next_dat;

    always_comb begin
        next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        next_dat = (next_ack & ~wb_we_i) ? bus.rdata : wb_dat_o;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // write lands on the edge where the master sees ack; lane 0 only
    assign bus.wr = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
    assign bus.adr = wb_adr_i;
    assign bus.wdata = wb_dat_i;
endmodule : acs_wb_slave
`default_nettype wire

// [rtl/acs_channel_map.sv]
// maps select code and result index to a multiplexer input code
// purely combinational
`timescale 1ns/1ps
`default_nettype none
module acs_channel_map (
    input wire logic multi,
    input wire logic len8,
    input wire logic [3:0] sel,
    input wire logic [2:0] idx,
    output logic [3:0] channel
);
    always_comb begin
        if (!multi) begin
            channel = sel;
        end else if (!len8) begin
            channel = {sel[3:2], idx[1:0]};
        end else begin
            channel = {sel[3], idx};
        end
    end
endmodule : acs_channel_map
`default_nettype wire

// [bench/acs_analog_model.sv]
// behavioural analog side: multiplexer, sample stage and comparator
// assumes one conv_done pulse per conv_start after a set delay
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic conv_start,
    input wire logic [3:0] conv_channel,
    input wire logic conv_abort,
    input wire logic [3:0] latency,
    output logic conv_done,
    output logic [9:0] conv_result
);
    logic busy;
    logic [3:0] wait_count;
    logic [3:0] channel;
    logic [5:0] serial;
    // result carries the channel seen and a running count
    always_ff @(posedge sys_clk) begin
        conv_done <= 1'b0;
        conv_result <= ~conv_result;
        if (!reset_n) begin
            busy <= 1'b0;
            serial <= 6'h00;
            conv_result <= 10'h155;
        end else if (conv_start) begin
            busy <= 1'b1;
            channel <= conv_channel;
            wait_count <= latency;
        end else if (conv_abort) begin
            busy <= 1'b0;
        end else if (busy && wait_count == 4'h0) begin
            busy <= 1'b0;
            conv_done <= 1'b1;
            serial <= serial + 6'h01;
            conv_result <= {channel, serial};
        end else if (busy) begin
            wait_count <= wait_count - 4'h1;
        end
    end
endmodule : acs_analog_model
`default_nettype wire

// [bench/acs_sequencer_top_tb.sv]
// self-checking bench for the conversion sequencer
// assumes the analog model answers every start after a set delay
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
    errors++; $display("FAIL %s exp %0h got %0h", nm, ex, gt); end end
module acs_sequencer_top_tb;
    typedef struct {logic [2:0] mode; logic [3:0] sel; logic [3:0] lat;}
        acs_row_type;
    logic sys_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
    logic [7:0] wb_adr_i, timing_control;
    logic [31:0] wb_dat_i, wb_dat_o, rd, r1;
    logic [3:0] wb_sel_i, conv_channel, latency;
    logic conv_start, conv_abort, conv_done;
    logic [9:0] conv_result;
    logic [3:0] chan_log[0:1023];
    int errors = 0, cmp_count = 0, start_count = 0, abort_count = 0;
    int base, n, k;
    acs_row_type rows[8] = '{'{3'h0, 4'h5, 4'h2}, '{3'h1, 4'hC, 4'h0},
        '{3'h2, 4'h4, 4'h3}, '{3'h2, 4'hF, 4'h1}, '{3'h3, 4'h0, 4'h0},
        '{3'h3, 4'h9, 4'h2}, '{3'h0, 4'h8, 4'h1}, '{3'h1, 4'hE, 4'h5}};
    acs_sequencer_top dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
        .conv_start(conv_start), .conv_channel(conv_channel),
        .conv_abort(conv_abort), .timing_control(timing_control),
        .conv_done(conv_done), .conv_result(conv_result));
    acs_analog_model model (.sys_clk(sys_clk), .reset_n(reset_n),
        .conv_start(conv_start), .conv_channel(conv_channel),
        .conv_abort(conv_abort), .latency(latency),
        .conv_done(conv_done), .conv_result(conv_result));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (conv_start) begin
            chan_log[start_count % 1024] <= conv_channel;
            start_count <= start_count + 1;
        end
        if (conv_abort) begin
            abort_count <= abort_count + 1;
        end
    end
    // channel expected for result index idx
    function automatic logic [3:0] exp_chan(input logic [2:0] mode,
            input logic [3:0] sel, input int idx);
        logic [2:0] i;
        i = idx[2:0];
        if (!mode[1]) return sel;
        if (!mode[0]) return {sel[3:2], i[1:0]};
        return {sel[3], i};
    endfunction : exp_chan
    task automatic wb_xfer(input logic we, input logic [7:0] adr,
            input logic [31:0] wd);
        int t;
        t = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge sys_clk);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 100);
        if (t >= 100) errors++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_xfer
    task automatic wait_starts(input int cnt);
        int t;
        for (t = 0; t < 2000 && start_count < cnt; t++) @(posedge sys_clk);
    endtask : wait_starts
    task automatic run_single(input acs_row_type r);
        int t;
        latency <= r.lat;
        base = start_count;
        n = r.mode[0] ? 8 : 4;
        wb_xfer(1'b1, 8'h04, {25'h0, r.mode, r.sel});
        t = 0;
        do begin
            wb_xfer(1'b0, 8'h08, 32'h0);
            t++;
        end while (rd[9] !== 1'b0 && t < 300);
        `CHK("status", {19'h0, r.mode, 2'b01, r.mode[0] ? 8'hFF : 8'h0F},
            rd)
        `CHK("starts", n, start_count - base)
        for (k = 0; k < n; k++) begin
            wb_xfer(1'b0, 8'h20 + 8'(4 * k), 32'h0);
            `CHK("result", exp_chan(r.mode, r.sel, k), rd[9:6])
            `CHK("channel", exp_chan(r.mode, r.sel, k), chan_log[base + k])
        end
    endtask : run_single
    task automatic report_and_stop;
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (50000) @(posedge sys_clk);
        errors++;
        report_and_stop();
    end
    initial begin
        reset_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'h0;
        latency = 4'h1;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (k = 0; k < 5; k++) begin
            wb_xfer(1'b0, 8'(4 * k), 32'h0);
            `CHK("reset value", 32'h0, rd)
        end
        `CHK("irq reset", 1'b0, irq)
        foreach (rows[i]) run_single(rows[i]);
        // continuous modes: wrap, flag, overwrite, then halt
        for (int m = 4; m < 8; m++) begin
            base = start_count;
            n = m[0] ? 8 : 4;
            k = abort_count;
            latency <= 4'h1;
            wb_xfer(1'b1, 8'h04, {25'h0, 3'(m), 4'h6});
            wait_starts(base + n + 2);
            wb_xfer(1'b0, 8'h08, 32'h0);
            `CHK("scan flag", 2'b11, rd[9:8])
            `CHK("wrap", exp_chan(3'(m), 4'h6, 0), chan_log[base + n])
            `CHK("wrap next", exp_chan(3'(m), 4'h6, 1), chan_log[base+n+1])
            wb_xfer(1'b0, 8'h20, 32'h0);
            r1 = rd;
            wait_starts(start_count + n + 1);
            wb_xfer(1'b0, 8'h20, 32'h0);
            `CHK("overwrite", 1'b1, r1 !== rd)
            wb_xfer(1'b1, 8'h00, 32'h5A);
            repeat (3) @(posedge sys_clk);
            wb_xfer(1'b0, 8'h08, 32'h0);
            `CHK("halt", {19'h0, 3'(m), 10'h0}, rd)
            `CHK("abort", k + 1, abort_count)
            `CHK("timing out", 8'h5A, timing_control)
        end
        // restart while busy
        latency <= 4'h4;
        wb_xfer(1'b1, 8'h04, 32'h13);
        wait_starts(start_count + 2);
        k = abort_count;
        run_single('{3'h0, 4'h7, 4'h4});
        `CHK("restart abort", k + 1, abort_count)
        // interrupts
        `CHK("irq masked", 1'b0, irq)
        wb_xfer(1'b1, 8'h10, 32'h3);
        repeat (2) @(posedge sys_clk);
        `CHK("irq on", 1'b1, irq)
        wb_xfer(1'b0, 8'h0C, 32'h0);
        `CHK("irq status", 32'h3, rd)
        wb_xfer(1'b1, 8'h0C, 32'h3);
        repeat (2) @(posedge sys_clk);
        `CHK("irq clear", 1'b0, irq)
        wb_xfer(1'b1, 8'h10, 32'h1);
        run_single('{3'h2, 4'h0, 4'h1});
        `CHK("irq seq", 1'b1, irq)
        // unmapped places
        wb_xfer(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        wb_xfer(1'b1, 8'h44, 32'h7F);
        wb_xfer(1'b0, 8'h04, 32'h0);
        `CHK("seq kept", 32'h20, rd)
        // reset in mid-run: conv_start, status, irq and timing_control back to their reset values
        wb_xfer(1'b1, 8'h04, 32'h46);
        wait_starts(start_count + 3);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        `CHK("reset start", 1'b0, conv_start)
        wb_xfer(1'b0, 8'h08, 32'h0);
        `CHK("reset status", 32'h0, rd)
        `CHK("reset irq", 1'b0, irq)
        `CHK("reset timing", 8'h00, timing_control)
        report_and_stop();
    end
endmodule : acs_sequencer_top_tb
`default_nettype wire
